//--- hw/rmsi_pkg.sv
// Shared constants and types for the robot mode and stop interlock
package rmsi_pkg;

  // System clock rate
  localparam int CLK_FREQ_MHZ = 10;
  // Debounce settle time of each contact input, in microseconds
  localparam int FILT_TIME_US = 1000;
  // Debounce settle time in clock cycles
  localparam int FILT_CYC_DEF = FILT_TIME_US * CLK_FREQ_MHZ;
  // Width of the debounce counter
  localparam int FILT_CW = 16;

  // Contact input count and positions in the filtered vector
  localparam int NIN = 5;
  localparam int IN_PERMIT = 0;
  localparam int IN_HHALT = 1;
  localparam int IN_STEP = 2;
  localparam int IN_INST = 3;
  localparam int IN_SKIP = 4;

  // Register port widths
  localparam int AW = 4;
  localparam int DW = 32;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CMD = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_ERROR = 4'h3;
  localparam logic [3:0] ADDR_STEP = 4'h4;

  // Command register bit positions (write-only pulses)
  localparam int CMD_MOTOR_ON = 0;
  localparam int CMD_MOTOR_OFF = 1;
  localparam int CMD_START = 2;
  localparam int CMD_MANUAL = 3;
  localparam int CMD_ERR_CLR = 4;

  // Status register field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_MOTOR = 4;
  localparam int ST_RUN = 5;
  localparam int ST_DECEL = 6;
  localparam int ST_STOP_PEND = 7;
  localparam int ST_IN_LSB = 8;
  // Error register valid bit position
  localparam int ER_VALID = 16;

  // Local mode selector codes
  localparam logic [1:0] SEL_MANUAL = 2'h0;
  localparam logic [1:0] SEL_TEACH = 2'h1;
  localparam logic [1:0] SEL_INT = 2'h2;
  localparam logic [1:0] SEL_EXT = 2'h3;
  localparam logic [1:0] SEL_RST = SEL_MANUAL;

  // Reported error codes
  localparam logic [15:0] ERR_HALT = 16'h2008;
  localparam logic [15:0] ERR_FALLBACK = 16'h21fc;
  localparam logic [15:0] ERR_SEL_AUTO = 16'h21f3;
  localparam logic [15:0] ERR_RESTRICT = 16'h21fd;
  localparam logic [15:0] ERR_MAN_SHORT = 16'h21f2;
  localparam logic [15:0] ERR_NONE = 16'h0000;

  // Operating mode
  typedef enum logic [3:0] {
    MODE_MANUAL   = 4'h1,
    MODE_TEACH    = 4'h2,
    MODE_INT_AUTO = 4'h4,
    MODE_EXT_AUTO = 4'h8
  } rmsi_mode_e;

  // Program execution state
  typedef enum logic [2:0] {
    RUN_IDLE  = 3'h1,
    RUN_EXEC  = 3'h2,
    RUN_DECEL = 3'h4
  } rmsi_run_e;

endpackage

//--- hw/rmsi_filter.sv
// Contact input synchroniser and debounce filter
`timescale 1ns/1ps
`default_nettype none
module rmsi_filter #(
  parameter int unsigned FILT_CYC = rmsi_pkg::FILT_CYC_DEF
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_raw,
  output logic      o_level
);
  localparam int CW = rmsi_pkg::FILT_CW;
  // Last count before the new level is accepted
  localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYC - 1);

  logic          meta_reg;  // First synchroniser stage
  logic          sync_reg;  // Second synchroniser stage
  logic [CW-1:0] cnt_reg;   // Cycles the new level has held
  logic [CW-1:0] cnt_next;  // Next counter value
  logic          lvl_reg;   // Accepted level
  logic          stable;    // Input agrees with accepted level
  logic          settled;   // New level held long enough

  assign stable = (sync_reg == lvl_reg);
  assign settled = (cnt_reg == CNT_LAST);
  assign cnt_next = (stable || settled) ? '0 : cnt_reg + 1'b1;
  assign o_level = lvl_reg;

  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_raw;
      sync_reg <= meta_reg;
    end
  end

  // Accept a new level only after it held for the full settle time
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      lvl_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (!stable && settled) begin
        lvl_reg <= sync_reg;
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/rmsi_interlock.sv
// Robot mode selection and stop interlock with its register port
//
// Summary of operation
// R1 - E-stop contact opens on any button
// R2 - Permit shorted allows automatic mode
// R3 - Permit open allows manual or teach only
// R4 - Permit lost in auto: manual, error 21FC
// R5 - Manual attempt with permit shorted: 21F2
// R6 - Auto selected, permit open: 21F3 held
// R7 - 21FD/21FC only toward restricted state
// R8 - Permit lost in external: drop external output
// R9 - Permit shorted blocks manual programs
// R10 - Pendantless: auto valid, external and start blocked; start is still accepted without a pendant while permit is shorted
// R11 - Hard halt open stops, blocks motor
// R12 - Hard halt open refuses all, error 2008
// R13 - Hard halt removes motor in any mode
// R14 - Running: decelerate, cut motor, go internal
// R15 - After halt program restarts at step zero
// R16 - Hard halt equals local stop button
// R17 - Hard halt has top priority
// R18 - Step-halt input step-stops all tasks
// R19 - Instant-halt stops programs immediately
// R20 - Skip aborts step, starts next step
// R21 - Step-halt: stop after step, keep mode
// R22 - Far side holds instant-halt 50 ms
// R23 - In-operation high while program executes
// R24 - Contact inputs synchronised and filtered
`timescale 1ns/1ps
`default_nettype none
module rmsi_interlock #(
  parameter int unsigned FILT_CYC = rmsi_pkg::FILT_CYC_DEF
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_auto_permit,
  input  wire logic        i_hard_halt,
  input  wire logic        i_step_halt,
  input  wire logic        i_instant_halt,
  input  wire logic        i_skip,
  input  wire logic [2:0]  i_estop_btn,
  input  wire logic        i_stop_btn,
  input  wire logic        i_pendant_present,
  input  wire logic        i_step_done,
  input  wire logic        i_at_rest,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  output logic             o_estop_closed,
  output logic             o_motor_pwr,
  output logic             o_in_operation,
  output logic             o_ext_mode,
  output logic             o_decel_req,
  output logic             o_step_abort,
  output logic             o_err_valid,
  output logic [15:0]      o_err_code
);

  // True for either automatic mode
  function automatic logic mode_auto(input rmsi_pkg::rmsi_mode_e m);
    return (m == rmsi_pkg::MODE_INT_AUTO) || (m == rmsi_pkg::MODE_EXT_AUTO);
  endfunction

  // Mode that a selector code asks for
  function automatic rmsi_pkg::rmsi_mode_e sel_mode(input logic [1:0] s);
    rmsi_pkg::rmsi_mode_e m;
    m = rmsi_pkg::MODE_MANUAL;
    case (s)
      rmsi_pkg::SEL_TEACH: m = rmsi_pkg::MODE_TEACH;
      rmsi_pkg::SEL_INT:   m = rmsi_pkg::MODE_INT_AUTO;
      rmsi_pkg::SEL_EXT:   m = rmsi_pkg::MODE_EXT_AUTO;
      default:             m = rmsi_pkg::MODE_MANUAL;
    endcase
    return m;
  endfunction

  logic [rmsi_pkg::NIN-1:0] raw_in;      // Contact inputs, 1 = shorted
  logic [rmsi_pkg::NIN-1:0] filt;        // Filtered contact levels
  logic [rmsi_pkg::NIN-1:0] filt_d_reg;  // Filtered levels one cycle back
  logic [1:0]               sel_reg;     // Local mode selector
  rmsi_pkg::rmsi_mode_e     mode_reg;    // Current operating mode
  rmsi_pkg::rmsi_mode_e     mode_next;
  rmsi_pkg::rmsi_run_e      run_reg;     // Program execution state
  rmsi_pkg::rmsi_run_e      run_next;
  logic                     motor_reg;   // Motor power
  logic                     motor_next;
  logic                     pend_reg;    // Step stop pending
  logic                     restart_reg; // Next start begins at step zero
  logic [7:0]               step_reg;    // Current program step
  logic [7:0]               step_next;
  logic                     err_v_reg;   // Error present
  logic [15:0]              err_c_reg;   // Error code shown

  logic permit;         // Auto-permit shorted
  logic permit_fall;    // Auto-permit just opened
  logic permit_rise;    // Auto-permit just shorted
  logic hh_open;        // Hard halt or local stop active
  logic step_fall;      // Step-halt just opened
  logic inst_fall;      // Instant-halt just opened
  logic skip_rise;      // Skip just shorted
  logic pendantless;    // No pendant attached
  logic int_ok;         // Internal auto selectable
  logic ext_ok;         // External auto selectable
  logic sel_blocked;    // Selector points at an unselectable mode
  logic in_exec;        // Program executing
  logic wr_ctrl;        // Write to selector register
  logic wr_cmd;         // Write to command register
  logic cmd_motor_on;   // Motor on request
  logic cmd_motor_off;  // Motor off request
  logic cmd_start;      // Program start request
  logic cmd_manual;     // Manual or teach-check run request
  logic cmd_clr;        // Error clear request
  logic start_auto_ok;  // Automatic start accepted
  logic start_man_ok;   // Manual run accepted
  logic err_halt;       // Refused while hard halt open
  logic err_fallback;   // Permit lost in auto
  logic err_restrict;   // Permit shorted in manual or teach
  logic err_man;        // Manual attempt with permit shorted
  logic err_any;        // Any error raised this cycle
  logic [15:0] err_set; // Highest priority code raised
  logic [31:0] rd_mux;  // Read data selected by address

  // R24 sync and filter
  assign raw_in = {i_skip, i_instant_halt, i_step_halt, i_hard_halt, i_auto_permit};
  genvar gi;
  generate
    for (gi = 0; gi < rmsi_pkg::NIN; gi = gi + 1) begin : g_filt
      rmsi_filter #(
        .FILT_CYC (FILT_CYC)
      ) u_filt (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_raw     (raw_in[gi]),
        .o_level   (filt[gi])
      );
    end
  endgenerate

  // Edges of the filtered contacts
  assign permit = filt[rmsi_pkg::IN_PERMIT];
  assign permit_fall = filt_d_reg[rmsi_pkg::IN_PERMIT] && !permit;
  assign permit_rise = !filt_d_reg[rmsi_pkg::IN_PERMIT] && permit;
  assign step_fall = filt_d_reg[rmsi_pkg::IN_STEP] && !filt[rmsi_pkg::IN_STEP];
  assign inst_fall = filt_d_reg[rmsi_pkg::IN_INST] && !filt[rmsi_pkg::IN_INST];
  assign skip_rise = !filt_d_reg[rmsi_pkg::IN_SKIP] && filt[rmsi_pkg::IN_SKIP];
  // R16 local stop button merged
  assign hh_open = !filt[rmsi_pkg::IN_HHALT] || i_stop_btn;
  assign in_exec = (run_reg == rmsi_pkg::RUN_EXEC);

  // Register port decode
  assign wr_ctrl = i_wr && (i_addr == rmsi_pkg::ADDR_CTRL);
  assign wr_cmd = i_wr && (i_addr == rmsi_pkg::ADDR_CMD);
  assign cmd_motor_on = wr_cmd && i_wdata[rmsi_pkg::CMD_MOTOR_ON];
  assign cmd_motor_off = wr_cmd && i_wdata[rmsi_pkg::CMD_MOTOR_OFF];
  assign cmd_start = wr_cmd && i_wdata[rmsi_pkg::CMD_START];
  assign cmd_manual = wr_cmd && i_wdata[rmsi_pkg::CMD_MANUAL];
  assign cmd_clr = wr_cmd && i_wdata[rmsi_pkg::CMD_ERR_CLR];

  // R2 R3 selectable modes
  assign pendantless = !i_pendant_present;
  // R10 pendantless keeps internal auto
  assign int_ok = permit || pendantless;
  assign ext_ok = permit && i_pendant_present;
  assign sel_blocked = ((sel_reg == rmsi_pkg::SEL_INT) && !int_ok)
                    || ((sel_reg == rmsi_pkg::SEL_EXT) && !ext_ok);

  // R10 automatic start needs permit
  assign start_auto_ok = cmd_start && mode_auto(mode_reg) && permit && motor_reg
                      && !hh_open && filt[rmsi_pkg::IN_STEP] && filt[rmsi_pkg::IN_INST];
  // R9 manual run blocked with permit shorted
  assign start_man_ok = cmd_manual && !mode_auto(mode_reg) && !permit && motor_reg
                     && !hh_open;

  // R12 refusal while halted
  assign err_halt = hh_open && (cmd_motor_on || cmd_start || cmd_manual);
  // R7 errors only toward restricted
  assign err_fallback = permit_fall && mode_auto(mode_reg) && !pendantless;
  assign err_restrict = permit_rise && !mode_auto(mode_reg);
  // R5 manual attempt with permit shorted
  assign err_man = cmd_manual && permit && !mode_auto(mode_reg);
  assign err_any = err_halt || err_fallback || sel_blocked || err_restrict || err_man;
  // R17 halt code ranks first
  assign err_set = err_halt     ? rmsi_pkg::ERR_HALT
                 : err_fallback ? rmsi_pkg::ERR_FALLBACK
                 : sel_blocked  ? rmsi_pkg::ERR_SEL_AUTO
                 : err_restrict ? rmsi_pkg::ERR_RESTRICT
                 : err_man      ? rmsi_pkg::ERR_MAN_SHORT
                 : rmsi_pkg::ERR_NONE;

  // Mode selection; the selector is followed only while no program runs
  always_comb begin
    mode_next = mode_reg;
    if (run_reg == rmsi_pkg::RUN_DECEL && i_at_rest
        && mode_reg == rmsi_pkg::MODE_EXT_AUTO) begin
      // R14 switch to internal after stop
      mode_next = rmsi_pkg::MODE_INT_AUTO;
    end else if (permit_fall && mode_auto(mode_reg)) begin
      // R4 R8 fall back on permit loss
      if (!pendantless) begin
        mode_next = rmsi_pkg::MODE_MANUAL;
      end else begin
        mode_next = rmsi_pkg::MODE_INT_AUTO;
      end
    end else if (run_reg == rmsi_pkg::RUN_IDLE && !sel_blocked) begin
      // R3 follow selector when allowed
      mode_next = sel_mode(sel_reg);
    end
  end

  // Program execution state
  always_comb begin
    run_next = run_reg;
    case (run_reg)
      rmsi_pkg::RUN_IDLE: begin
        if (start_auto_ok || start_man_ok) begin
          run_next = rmsi_pkg::RUN_EXEC;
        end
      end
      rmsi_pkg::RUN_EXEC: begin
        if (hh_open) begin
          // R17 R14 hard halt decelerates first
          run_next = rmsi_pkg::RUN_DECEL;
        end else if (inst_fall) begin
          // R19 immediate stop
          run_next = rmsi_pkg::RUN_IDLE;
        end else if (permit_fall && mode_auto(mode_reg) && !pendantless) begin
          run_next = rmsi_pkg::RUN_IDLE;
        end else if (i_step_done && (pend_reg || step_fall)) begin
          // R21 stop at end of step
          run_next = rmsi_pkg::RUN_IDLE;
        end
      end
      rmsi_pkg::RUN_DECEL: begin
        if (i_at_rest) begin
          run_next = rmsi_pkg::RUN_IDLE;
        end
      end
      default: run_next = rmsi_pkg::RUN_IDLE;
    endcase
  end

  // Motor power
  always_comb begin
    motor_next = motor_reg;
    if (hh_open) begin
      // R11 R13 cut power unless executing or still decelerating
      if (!in_exec && !(run_reg == rmsi_pkg::RUN_DECEL && !i_at_rest)) begin
        motor_next = 1'b0;
      end
    end else if (cmd_motor_off) begin
      motor_next = 1'b0;
    end else if (cmd_motor_on) begin
      motor_next = 1'b1;
    end
  end

  // Step position
  always_comb begin
    step_next = step_reg;
    if (run_reg == rmsi_pkg::RUN_IDLE && run_next == rmsi_pkg::RUN_EXEC
        && restart_reg) begin
      // R15 restart at first step
      step_next = 8'h00;
    end else if (in_exec && (i_step_done || skip_rise)) begin
      // R20 skip moves to next step
      step_next = step_reg + 8'h01;
    end
  end

  // Read data selection
  assign rd_mux = (i_addr == rmsi_pkg::ADDR_CTRL) ? {30'h0, sel_reg}
                : (i_addr == rmsi_pkg::ADDR_STATUS) ?
                  {19'h0, filt, pend_reg, (run_reg == rmsi_pkg::RUN_DECEL),
                   in_exec, motor_reg, mode_reg}
                : (i_addr == rmsi_pkg::ADDR_ERROR) ? {15'h0, err_v_reg, err_c_reg}
                : (i_addr == rmsi_pkg::ADDR_STEP) ? {24'h0, step_reg}
                : 32'h0;

  // Selector, mode, run and motor state
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      filt_d_reg <= '0;
      sel_reg <= rmsi_pkg::SEL_RST;
      mode_reg <= rmsi_pkg::MODE_MANUAL;
      run_reg <= rmsi_pkg::RUN_IDLE;
      motor_reg <= 1'b0;
      step_reg <= 8'h00;
    end else begin
      filt_d_reg <= filt;
      if (wr_ctrl) begin
        sel_reg <= i_wdata[1:0];
      end
      mode_reg <= mode_next;
      run_reg <= run_next;
      motor_reg <= motor_next;
      step_reg <= step_next;
    end
  end

  // Stop pending and restart flags
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      // R18 step-halt arms a stop of all tasks
      pend_reg <= (run_next == rmsi_pkg::RUN_EXEC) && (pend_reg || step_fall);
      // R15 a hard halt forgets the position
      restart_reg <= hh_open || (restart_reg && !(run_next == rmsi_pkg::RUN_EXEC));
    end
  end

  // Error register; a new error wins over a clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      err_v_reg <= 1'b0;
      err_c_reg <= rmsi_pkg::ERR_NONE;
    end else if (err_any) begin
      // R6 blocked selector re-raises every cycle
      err_v_reg <= 1'b1;
      err_c_reg <= err_set;
    end else if (cmd_clr) begin
      err_v_reg <= 1'b0;
      err_c_reg <= rmsi_pkg::ERR_NONE;
    end
  end

  // Output flops
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
      o_estop_closed <= 1'b0;
      o_motor_pwr <= 1'b0;
      o_in_operation <= 1'b0;
      o_ext_mode <= 1'b0;
      o_decel_req <= 1'b0;
      o_step_abort <= 1'b0;
      o_err_valid <= 1'b0;
      o_err_code <= rmsi_pkg::ERR_NONE;
    end else begin
      o_rdata <= i_rd ? rd_mux : 32'h0;
      // R1 contact opens on any button
      o_estop_closed <= ~|i_estop_btn;
      o_motor_pwr <= motor_next;
      // R23 in operation while executing
      o_in_operation <= (run_next == rmsi_pkg::RUN_EXEC);
      // R8 external output follows mode
      o_ext_mode <= (mode_next == rmsi_pkg::MODE_EXT_AUTO);
      o_decel_req <= (run_next == rmsi_pkg::RUN_DECEL);
      // R20 abort pulse on skip
      o_step_abort <= in_exec && skip_rise && !hh_open;
      o_err_valid <= err_any || (err_v_reg && !cmd_clr);
      o_err_code <= err_any ? err_set : (cmd_clr ? rmsi_pkg::ERR_NONE : err_c_reg);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // Hard halt hits a running program
  sequence s_halt_in_run;
    in_exec && hh_open;
  endsequence

  // Deceleration reaches rest
  sequence s_decel_done;
    run_reg == rmsi_pkg::RUN_DECEL && i_at_rest;
  endsequence

  // Step-halt opens mid-step with no other stop cause
  sequence s_step_arm;
    in_exec && step_fall && !i_step_done && !hh_open && !inst_fall && !permit_fall;
  endsequence

  // Step stop armed and the step then ends
  sequence s_step_stop;
    in_exec && (pend_reg || step_fall) && i_step_done && !hh_open && !inst_fall
    && !permit_fall;
  endsequence

  a_estop_open: assert property (|i_estop_btn |=> !o_estop_closed) // R1
    else $error("estop contact stayed closed");
  a_auto_refuse: assert property ((!permit && i_pendant_present
    && !mode_auto(mode_reg)) |=> !mode_auto(mode_reg)) // R3
    else $error("auto mode entered with permit open");
  a_fallback_err: assert property ((err_fallback && !hh_open)
    |=> mode_reg == rmsi_pkg::MODE_MANUAL && o_err_code == rmsi_pkg::ERR_FALLBACK) // R4
    else $error("no fallback on permit loss");
  a_sel_error: assert property (sel_blocked |=> o_err_valid && !mode_auto(mode_reg)
    || o_err_code == rmsi_pkg::ERR_SEL_AUTO || o_err_code == rmsi_pkg::ERR_HALT) // R6
    else $error("blocked selector error not held");
  a_ext_drop: assert property ((permit_fall && o_ext_mode) |=> !o_ext_mode) // R8
    else $error("external output kept after permit loss");
  a_manual_block: assert property ((cmd_manual && permit && run_reg == rmsi_pkg::RUN_IDLE)
    |=> !o_in_operation && o_err_valid) // R9
    else $error("manual run with permit shorted");
  a_motor_refuse: assert property ((hh_open && cmd_motor_on)
    |=> !o_motor_pwr && o_err_code == rmsi_pkg::ERR_HALT) // R12
    else $error("motor enabled during hard halt");
  a_halt_idle: assert property ((hh_open && run_reg == rmsi_pkg::RUN_IDLE)
    |=> !o_motor_pwr) // R13
    else $error("motor kept while halted idle");
  a_decel_seq: assert property (s_halt_in_run |=> o_decel_req && o_motor_pwr
    && !o_in_operation) // R14
    else $error("no deceleration on hard halt");
  a_decel_end: assert property (s_decel_done |=> !o_motor_pwr && !o_decel_req
    && mode_reg != rmsi_pkg::MODE_EXT_AUTO) // R14
    else $error("motor or external mode kept after stop");
  a_inst_stop: assert property ((in_exec && inst_fall && !hh_open)
    |=> !o_in_operation && run_reg == rmsi_pkg::RUN_IDLE) // R19
    else $error("instant halt did not stop");
  a_step_arm: assert property (s_step_arm |=> pend_reg && o_in_operation) // R18
    else $error("step stop not armed");
  a_step_stop: assert property (s_step_stop |=> !o_in_operation
    && $stable(mode_reg)) // R21
    else $error("step stop failed or mode lost");
  a_skip_abort: assert property ((in_exec && skip_rise && !hh_open)
    |=> o_step_abort && step_reg == $past(step_reg) + 8'h01) // R20
    else $error("skip did not advance step");

endmodule
`default_nettype wire

//--- testbench/rmsi_panel_model.sv
// Operating panel and program sequencer model at the far side of the interlock
`timescale 1ns/1ps
`default_nettype none
module rmsi_panel_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [4:0] i_cont,
  input  wire logic       i_in_operation,
  input  wire logic       i_decel_req,
  output logic            o_auto_permit,
  output logic            o_hard_halt,
  output logic            o_step_halt,
  output logic            o_instant_halt,
  output logic            o_skip,
  output logic            o_step_done,
  output logic            o_at_rest
);
  logic [3:0] cnt_reg;  // Cycles since motion began
  // Count only while the robot moves
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 4'h0;
    end else if (!(i_in_operation || i_decel_req)) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // contacts held as the bench orders
  assign {o_skip, o_instant_halt, o_step_halt, o_hard_halt, o_auto_permit} = i_cont;
  // Steps end every sixteen cycles of running
  assign o_step_done = i_in_operation && (cnt_reg == 4'hf);
  // Rest is reported during a deceleration while the motion count is 8 to 15 (bit 3 set)
  assign o_at_rest = i_decel_req && cnt_reg[3];
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the robot mode and stop interlock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int FC = 4;         // Short debounce for simulation
  logic        i_clk_sys = 1'b0; // System clock
  logic        i_rst = 1'b1;     // Reset
  logic [4:0]  cont = 5'h00;     // Contacts {skip,inst,step,hard,permit}
  logic [2:0]  btn = 3'h0;       // Emergency buttons
  logic [3:0]  i_addr = 4'h0;    // Register address
  logic [31:0] i_wdata = 32'h0;  // Register write data
  logic        i_wr = 1'b0;      // Write strobe
  logic        i_rd = 1'b0;      // Read strobe
  logic        stop_btn = 1'b0;  // Local stop button
  logic        pend = 1'b1;      // Pendant attached
  wire  [31:0] rdata;
  wire  [15:0] errc;
  wire         permit, hhalt, shalt, ihalt, skip, done, rest;
  wire         estop, motor, inop, extm, decel, abort, errv;
  int          fails = 0;
  int          comparisons = 0;

  rmsi_interlock #(.FILT_CYC(FC)) DUT (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_auto_permit(permit), .i_hard_halt(hhalt),
    .i_step_halt(shalt), .i_instant_halt(ihalt), .i_skip(skip), .i_estop_btn(btn),
    .i_stop_btn(stop_btn), .i_pendant_present(pend), .i_step_done(done), .i_at_rest(rest),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .o_estop_closed(estop), .o_motor_pwr(motor), .o_in_operation(inop),
    .o_ext_mode(extm), .o_decel_req(decel), .o_step_abort(abort), .o_err_valid(errv),
    .o_err_code(errc));

  rmsi_panel_model PANEL (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cont(cont), .i_in_operation(inop),
    .i_decel_req(decel), .o_auto_permit(permit), .o_hard_halt(hhalt),
    .o_step_halt(shalt), .o_instant_halt(ihalt), .o_skip(skip), .o_step_done(done),
    .o_at_rest(rest));

  // Clock at 10 MHz
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // Verdict and end of run
  task automatic final_report();
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask

  // One-cycle read, data checked under a mask in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(rdata & m, exp);
  endtask

  // Observed outputs by index
  function automatic logic [31:0] pick(input int w);
    case (w)
      0: return {31'h0, inop};
      1: return {31'h0, motor};
      2: return {31'h0, decel};
      3: return {31'h0, abort};
      4: return {31'h0, extm};
      default: return {16'h0, errc};
    endcase
  endfunction

  // Bounded wait for an output value
  task automatic wt(input int w, input logic [31:0] v);
    int n;
    for (n = 0; n < 300; n++) begin
      @(posedge i_clk_sys);
      #1;
      if (pick(w) === v) break;
    end
    chk(pick(w), v);
    if (n == 300) final_report();
  endtask

  // New contact levels, then let the filter settle
  task automatic setc(input logic [4:0] v);
    @(posedge i_clk_sys);
    cont <= v;
    repeat (FC + 5) @(posedge i_clk_sys);
    #1;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(4'h2, 32'h1fff, 32'h1);
    wr(4'h1, 32'h1);
    rd(4'h3, 32'h1ffff, 32'h12008);
    chk(motor, 1'b0);
    chk(estop, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge i_clk_sys);
      btn <= 3'(1 << i);
      repeat (2) @(posedge i_clk_sys);
      #1;
      chk(estop, 1'b0);
    end
    @(posedge i_clk_sys);
    btn <= 3'h0;
    wr(4'h1, 32'h10);
    setc(5'h0f);
    rd(4'h3, 32'h1ffff, 32'h121fd);
    wr(4'h1, 32'h10);
    wr(4'h1, 32'h8);
    rd(4'h3, 32'h1ffff, 32'h121f2);
    chk(inop, 1'b0);
    wr(4'h1, 32'h10);
    wr(4'h0, 32'h2);
    wr(4'h1, 32'h1);
    rd(4'h2, 32'h1f, 32'h14);
    wr(4'h1, 32'h4);
    wt(0, 1);
    @(posedge i_clk_sys);
    cont <= 5'h1f;
    wt(3, 1);
    setc(5'h0f);
    setc(5'h07);
    wt(0, 0);
    setc(5'h0f);
    rd(4'h2, 32'hf, 32'h4);
    wr(4'h1, 32'h4);
    wt(0, 1);
    @(posedge i_clk_sys);
    cont <= 5'h0b;
    wt(0, 0);
    rd(4'h2, 32'hf, 32'h4);
    setc(5'h0f);
    wr(4'h1, 32'h4);
    wt(0, 1);
    @(posedge i_clk_sys);
    cont <= 5'h0d;
    wt(2, 1);
    chk(motor, 1'b1);
    wt(1, 0);
    chk(inop, 1'b0);
    wr(4'h1, 32'h1);
    rd(4'h3, 32'h1ffff, 32'h12008);
    setc(5'h0f);
    wr(4'h1, 32'h10);
    wr(4'h1, 32'h1);
    chk(motor, 1'b1);
    wr(4'h1, 32'h4);
    rd(4'h4, 32'hff, 32'h0);
    setc(5'h07);
    setc(5'h0f);
    wr(4'h0, 32'h3);
    wt(4, 1);
    @(posedge i_clk_sys);
    cont <= 5'h0e;
    wt(4, 0);
    chk(errc, 32'h21fc);
    rd(4'h2, 32'hf, 32'h1);
    wt(5, 32'h21f3);
    wr(4'h1, 32'h10);
    repeat (3) @(posedge i_clk_sys);
    chk(errc, 32'h21f3);
    chk(errv, 1'b1);
    wr(4'h0, 32'h2);
    rd(4'h2, 32'hf, 32'h1);
    wr(4'h0, 32'h1);
    rd(4'h2, 32'hf, 32'h2);
    @(posedge i_clk_sys);
    pend <= 1'b0;
    wr(4'h0, 32'h2);
    rd(4'h2, 32'hf, 32'h4);
    wr(4'h1, 32'h4);
    chk(inop, 1'b0);
    @(posedge i_clk_sys);
    stop_btn <= 1'b1;
    wt(1, 0);
    wr(4'h1, 32'h1);
    rd(4'h3, 32'h1ffff, 32'h12008);
    final_report();
  end
endmodule
`default_nettype wire
